//--- phy_mgmt_pkg.sv
// constants, field layouts and types shared by the management register block
package phy_mgmt_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int         REG_W             = 16;
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_EVENT_STATUS  = 5'h01;

    // basic_control bit positions
    localparam int CTL_RESET     = 15;
    localparam int CTL_LOOPBACK  = 14;
    localparam int CTL_RATE_100  = 13;
    localparam int CTL_AN_EN     = 12;
    localparam int CTL_LOW_POWER = 11;
    localparam int CTL_ISOLATE   = 10;
    localparam int CTL_RESTART   = 9;
    localparam int CTL_DUPLEX    = 8;
    localparam int CTL_COL_TEST  = 7;

    // event_status bit positions
    localparam int EVT_FAULT     = 0;
    localparam int EVT_LINK      = 1;
    localparam int EVT_STATE_LSB = 2;
    localparam int STATE_W       = 3;

    // latch kinds
    localparam int latch_high_kind    = 0;
    localparam int latch_low_kind     = 1;
    localparam int latch_maximum_kind = 2;

    // ----------------------------------------------------------------
    // management frame
    // ----------------------------------------------------------------
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [3:0] HDR_BITS  = 4'hc;
    localparam logic [3:0] TA_LAST   = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hf;
    localparam logic [4:0] ADDR_ZERO = 5'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int SW_RESET_NS  = 1000;
    localparam int SW_RESET_CYC = (SW_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int STRAP_WAIT   = 3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic reset;
        logic loopback;
        logic rate_100;
        logic an_en;
        logic low_power;
        logic isolate;
        logic an_restart;
        logic full_duplex;
        logic col_test;
    } ctrl_t;

    localparam ctrl_t CTRL_DEFAULT = '{reset: 1'b0, loopback: 1'b0, rate_100: 1'b1,
                                       an_en: 1'b1, low_power: 1'b0, isolate: 1'b0,
                                       an_restart: 1'b0, full_duplex: 1'b0,
                                       col_test: 1'b0};

    typedef struct packed {
        logic       mdc;
        logic       mdio;
        logic       sel;
        logic       rate_100;
        logic       an_en;
        logic       full_duplex;
        logic [4:0] phy_addr;
    } pins_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR  = 4'h2,
        ST_TA   = 4'h4,
        ST_DATA = 4'h8
    } mgmt_state_t;

endpackage

//--- latch_track.sv
// one latching status field: high, low or maximum kind
`timescale 1ns/1ps
`default_nettype none
module latch_track #(
    parameter int           W    = 1,
    parameter int           KIND = 0,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // control
    input  wire logic         reinit,
    input  wire logic         reload,
    // monitored value and held value
    input  wire logic [W-1:0] cur,
    output logic      [W-1:0] q
);
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_q = q;
        if (reinit) begin
            nxt_q = INIT;
        end else if (reload) begin
            // whole group reloads at once so no bit mixes two moments
            nxt_q = cur;
        end else if (KIND == phy_mgmt_pkg::latch_high_kind) begin
            nxt_q = q | cur;
        end else if (KIND == phy_mgmt_pkg::latch_low_kind) begin
            nxt_q = q & cur;
        end else if (cur > q) begin
            nxt_q = cur;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= INIT;
        end else begin
            q <= nxt_q;
        end
    end
endmodule
`default_nettype wire

//--- phy_mgmt_control_register.sv
// management frame slave, basic control register and its effects
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_control_register #(
    parameter int SW_RESET_CYC = phy_mgmt_pkg::SW_RESET_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // management pins
    input  wire logic       mdc,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe,
    // strap pins
    input  wire logic       hardware_strap_select_pin,
    input  wire logic       strap_rate_100,
    input  wire logic       strap_an_en,
    input  wire logic       strap_full_duplex,
    input  wire logic [4:0] phy_addr_strap,
    // monitored internal state
    input  wire logic       fault_event,
    input  wire logic       link_ok,
    input  wire logic [2:0] train_state,
    input  wire logic       an_started,
    // mac side transmit and line side receive
    input  wire logic       tx_en,
    input  wire logic [3:0] txd,
    input  wire logic       line_rx_dv,
    input  wire logic [3:0] line_rxd,
    input  wire logic       line_col,
    // mac side receive
    output logic            rx_dv,
    output logic [3:0]      rxd,
    output logic            col,
    // operating controls
    output logic            tp_tx_en,
    output logic            tp_rx_en,
    output logic            col_det_en,
    output logic            rate_100,
    output logic            an_enable,
    output logic            an_restart,
    output logic            full_duplex,
    output logic            low_power,
    output logic            isolate,
    output logic            loopback,
    output logic            machines_idle
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    phy_mgmt_pkg::pins_t s1_ff, s2_ff, nxt_s1;
    logic mdc_d_ff, nxt_mdc_d, rise;

    always_comb begin
        nxt_s1    = {mdc, mdio_i, hardware_strap_select_pin, strap_rate_100,
                     strap_an_en, strap_full_duplex, phy_addr_strap};
        nxt_mdc_d = s2_ff.mdc;
        rise      = s2_ff.mdc & ~mdc_d_ff;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            mdc_d_ff <= 1'b0;
        end else begin
            s1_ff    <= nxt_s1;
            s2_ff    <= s1_ff;
            mdc_d_ff <= nxt_mdc_d;
        end
    end

    // ----------------------------------------------------------------
    // management frame engine
    // ----------------------------------------------------------------
    phy_mgmt_pkg::mgmt_state_t st_ff, nxt_st;
    phy_mgmt_pkg::ctrl_t       ctrl_ff, nxt_ctrl;
    logic [1:0]  pre_ff, nxt_pre;
    logic [11:0] hdr_ff, nxt_hdr;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic [15:0] sh_ff, nxt_sh, rd_word;
    logic        mdio_o_ff, nxt_mdio_o, mdio_oe_ff, nxt_mdio_oe;
    logic        busy, hit, evt_reload, wr_stb;
    logic [15:0] wr_word;
    logic [4:0]  addr_ff;
    logic        fault_q, link_q;
    logic [2:0]  state_q;

    assign busy = ctrl_ff.reset;
    assign hit  = (hdr_ff[9:5] == addr_ff);

    always_comb begin
        rd_word = 16'h0000;
        if (hdr_ff[4:0] == phy_mgmt_pkg::REG_BASIC_CONTROL) begin
            rd_word[15:7] = ctrl_ff;
        end else if (hdr_ff[4:0] == phy_mgmt_pkg::REG_EVENT_STATUS) begin
            rd_word[phy_mgmt_pkg::EVT_FAULT] = fault_q;
            rd_word[phy_mgmt_pkg::EVT_LINK]  = link_q;
            rd_word[phy_mgmt_pkg::EVT_STATE_LSB +: phy_mgmt_pkg::STATE_W] = state_q;
        end
    end

    always_comb begin
        nxt_st      = st_ff;
        nxt_pre     = pre_ff;
        nxt_hdr     = hdr_ff;
        nxt_cnt     = cnt_ff;
        nxt_sh      = sh_ff;
        nxt_mdio_o  = mdio_o_ff;
        nxt_mdio_oe = mdio_oe_ff;
        evt_reload  = 1'b0;
        wr_stb      = 1'b0;
        wr_word     = {sh_ff[14:0], s2_ff.mdio};
        if (busy) begin
            // accesses during soft reset are dropped whole
            nxt_st      = phy_mgmt_pkg::ST_IDLE;
            nxt_pre     = 2'h0;
            nxt_mdio_oe = 1'b0;
        end else if (rise) begin
            case (st_ff)
                phy_mgmt_pkg::ST_IDLE: begin
                    nxt_pre = {pre_ff[0], s2_ff.mdio};
                    nxt_cnt = 4'h0;
                    if ({pre_ff, s2_ff.mdio} == 3'h5) begin
                        nxt_st = phy_mgmt_pkg::ST_HDR;
                    end
                end
                phy_mgmt_pkg::ST_HDR: begin
                    nxt_hdr = {hdr_ff[10:0], s2_ff.mdio};
                    nxt_cnt = cnt_ff + 4'h1;
                    if (nxt_cnt == phy_mgmt_pkg::HDR_BITS) begin
                        nxt_st  = phy_mgmt_pkg::ST_TA;
                        nxt_cnt = 4'h0;
                    end
                end
                phy_mgmt_pkg::ST_TA: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (hdr_ff[11:10] == phy_mgmt_pkg::OP_READ && hit) begin
                        if (cnt_ff == 4'h0) begin
                            nxt_mdio_oe = 1'b1;
                            nxt_mdio_o  = 1'b0;
                            nxt_sh      = rd_word;
                            evt_reload  = (hdr_ff[4:0] == phy_mgmt_pkg::REG_EVENT_STATUS);
                        end else begin
                            nxt_mdio_o = sh_ff[15];
                            nxt_sh     = {sh_ff[14:0], 1'b0};
                        end
                    end
                    if (cnt_ff == phy_mgmt_pkg::TA_LAST) begin
                        nxt_st  = phy_mgmt_pkg::ST_DATA;
                        nxt_cnt = 4'h0;
                    end
                end
                phy_mgmt_pkg::ST_DATA: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (mdio_oe_ff) begin
                        nxt_mdio_o = sh_ff[15];
                        nxt_sh     = {sh_ff[14:0], 1'b0};
                    end else begin
                        nxt_sh = wr_word;
                    end
                    if (cnt_ff == phy_mgmt_pkg::DATA_LAST) begin
                        nxt_st      = phy_mgmt_pkg::ST_IDLE;
                        nxt_pre     = 2'h0;
                        nxt_mdio_oe = 1'b0;
                        wr_stb      = (hdr_ff[11:10] == phy_mgmt_pkg::OP_WRITE) && hit;
                    end
                end
                default: begin
                    nxt_st = phy_mgmt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff      <= phy_mgmt_pkg::ST_IDLE;
            pre_ff     <= 2'h0;
            hdr_ff     <= 12'h000;
            cnt_ff     <= 4'h0;
            sh_ff      <= 16'h0000;
            mdio_o_ff  <= 1'b0;
            mdio_oe_ff <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            pre_ff     <= nxt_pre;
            hdr_ff     <= nxt_hdr;
            cnt_ff     <= nxt_cnt;
            sh_ff      <= nxt_sh;
            mdio_o_ff  <= nxt_mdio_o;
            mdio_oe_ff <= nxt_mdio_oe;
        end
    end

    // ----------------------------------------------------------------
    // control register, soft reset and strap capture
    // ----------------------------------------------------------------
    logic [15:0] sw_cnt_ff, nxt_sw_cnt;
    logic [1:0]  strap_cnt_ff, nxt_strap_cnt;
    logic [4:0]  nxt_addr;
    logic        lp_d_ff, nxt_lp_d, reinit, hw_mode;

    assign hw_mode = ~s2_ff.sel;
    assign reinit  = busy | (ctrl_ff.low_power & ~lp_d_ff);

    always_comb begin
        nxt_ctrl      = ctrl_ff;
        nxt_sw_cnt    = sw_cnt_ff;
        nxt_strap_cnt = strap_cnt_ff;
        nxt_addr      = addr_ff;
        nxt_lp_d      = ctrl_ff.low_power;
        // strap is caught after release, once the synchroniser has filled
        if (strap_cnt_ff != 2'(phy_mgmt_pkg::STRAP_WAIT)) begin
            nxt_strap_cnt = strap_cnt_ff + 2'h1;
            nxt_addr      = s2_ff.phy_addr;
            nxt_ctrl.isolate = (s2_ff.phy_addr == phy_mgmt_pkg::ADDR_ZERO);
        end
        if (an_started) begin
            nxt_ctrl.an_restart = 1'b0;
        end
        if (busy) begin
            nxt_ctrl         = phy_mgmt_pkg::CTRL_DEFAULT;
            nxt_ctrl.isolate = (addr_ff == phy_mgmt_pkg::ADDR_ZERO);
            nxt_ctrl.reset   = 1'b1;
            nxt_sw_cnt       = sw_cnt_ff - 16'h0001;
            if (sw_cnt_ff == 16'h0001) begin
                nxt_ctrl.reset = 1'b0;
            end
        end else if (wr_stb && hdr_ff[4:0] == phy_mgmt_pkg::REG_BASIC_CONTROL) begin
            // reserved bits 6 to 0 are not stored
            nxt_ctrl = wr_word[15:7];
            nxt_ctrl.an_restart = wr_word[phy_mgmt_pkg::CTL_RESTART]
                                  & (hw_mode ? s2_ff.an_en : ctrl_ff.an_en);
            if (wr_word[phy_mgmt_pkg::CTL_RESET]) begin
                nxt_sw_cnt = 16'(SW_RESET_CYC);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff      <= phy_mgmt_pkg::CTRL_DEFAULT;
            sw_cnt_ff    <= 16'h0000;
            strap_cnt_ff <= 2'h0;
            addr_ff      <= 5'h00;
            lp_d_ff      <= 1'b0;
        end else begin
            ctrl_ff      <= nxt_ctrl;
            sw_cnt_ff    <= nxt_sw_cnt;
            strap_cnt_ff <= nxt_strap_cnt;
            addr_ff      <= nxt_addr;
            lp_d_ff      <= nxt_lp_d;
        end
    end

    // ----------------------------------------------------------------
    // latching status fields
    // ----------------------------------------------------------------
    latch_track #(.W(1), .KIND(phy_mgmt_pkg::latch_high_kind), .INIT(1'b0)) u_fault (
        .clk     (clk),
        .sys_rst (sys_rst),
        .reinit  (reinit),
        .reload  (evt_reload),
        .cur     (fault_event),
        .q       (fault_q)
    );

    latch_track #(.W(1), .KIND(phy_mgmt_pkg::latch_low_kind), .INIT(1'b0)) u_link (
        .clk     (clk),
        .sys_rst (sys_rst),
        .reinit  (reinit),
        .reload  (evt_reload),
        .cur     (link_ok),
        .q       (link_q)
    );

    latch_track #(.W(3), .KIND(phy_mgmt_pkg::latch_maximum_kind), .INIT(3'h0)) u_state (
        .clk     (clk),
        .sys_rst (sys_rst),
        .reinit  (reinit),
        .reload  (evt_reload),
        .cur     (train_state),
        .q       (state_q)
    );

    // ----------------------------------------------------------------
    // operating controls and loopback data path
    // ----------------------------------------------------------------
    logic [19:0] out_ff, nxt_out;
    logic        lb, cdet, quiet;

    always_comb begin
        lb    = ctrl_ff.loopback;
        cdet  = ~lb | ctrl_ff.col_test;
        quiet = ctrl_ff.isolate | ctrl_ff.low_power | busy;
        nxt_out[0]  = ~lb & ~ctrl_ff.low_power;
        nxt_out[1]  = ~lb & ~ctrl_ff.low_power;
        nxt_out[2]  = cdet;
        nxt_out[3]  = hw_mode ? s2_ff.rate_100 : ctrl_ff.rate_100;
        nxt_out[4]  = hw_mode ? s2_ff.an_en : ctrl_ff.an_en;
        nxt_out[5]  = ctrl_ff.an_restart;
        nxt_out[6]  = hw_mode ? s2_ff.full_duplex : ctrl_ff.full_duplex;
        nxt_out[7]  = ctrl_ff.low_power;
        nxt_out[8]  = ctrl_ff.isolate;
        nxt_out[9]  = lb;
        nxt_out[10] = busy;
        // one cycle of delay is far below 512 bit times at either rate
        nxt_out[11] = ~quiet & (lb ? tx_en : line_rx_dv);
        nxt_out[15:12] = quiet ? 4'h0 : (lb ? txd : line_rxd);
        nxt_out[16] = ~quiet & cdet & (lb ? tx_en : line_col);
        nxt_out[17] = mdio_o_ff;
        nxt_out[18] = mdio_oe_ff;
        nxt_out[19] = 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_ff <= 20'h0_0000;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign tp_tx_en      = out_ff[0];
    assign tp_rx_en      = out_ff[1];
    assign col_det_en    = out_ff[2];
    assign rate_100      = out_ff[3];
    assign an_enable     = out_ff[4];
    assign an_restart    = out_ff[5];
    assign full_duplex   = out_ff[6];
    assign low_power     = out_ff[7];
    assign isolate       = out_ff[8];
    assign loopback      = out_ff[9];
    assign machines_idle = out_ff[10];
    assign rx_dv         = out_ff[11];
    assign rxd           = out_ff[15:12];
    assign col           = out_ff[16];
    assign mdio_o        = mdio_o_ff;
    assign mdio_oe       = mdio_oe_ff;
endmodule
`default_nettype wire

//--- phy_mgmt_control_register_note_end.sv
// intentionally empty design file marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- phy_mgmt_control_register_asserts.sv
// concurrent checks on the management register block ports
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_control_register_asserts #(
    parameter int SW_RESET_CYC = phy_mgmt_pkg::SW_RESET_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins watched
    input wire logic hardware_strap_select_pin,
    input wire logic strap_rate_100,
    input wire logic strap_full_duplex,
    input wire logic an_started,
    input wire logic tx_en,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    // outputs watched
    input wire logic rx_dv,
    input wire logic tp_tx_en,
    input wire logic tp_rx_en,
    input wire logic col_det_en,
    input wire logic rate_100,
    input wire logic an_enable,
    input wire logic an_restart,
    input wire logic full_duplex,
    input wire logic low_power,
    input wire logic isolate,
    input wire logic loopback,
    input wire logic machines_idle
);
    // ----------------------------------------------------------------
    // helper and assertions
    // ----------------------------------------------------------------
    // busy time is far past any repetition, so it is counted instead
    logic [15:0] idle_cnt_ff;
    logic [15:0] nxt_idle_cnt;
    always_comb nxt_idle_cnt = machines_idle ? idle_cnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) idle_cnt_ff <= 16'h0000;
        else idle_cnt_ff <= nxt_idle_cnt;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    line_off_a: assert property (loopback && $past(loopback)
        |-> !tp_tx_en && !tp_rx_en) else $error("line path on in loopback");
    det_loop_a: assert property (!col_det_en && !$past(sys_rst) && !machines_idle
        |-> loopback || $past(loopback)) else $error("detector off outside loopback");
    loop_rx_a: assert property ($rose(tx_en) && loopback && !isolate && !low_power
        && !machines_idle |-> ##[1:8] rx_dv) else $error("loopback receive late");
    hw_rate_a: assert property ((!hardware_strap_select_pin && $stable(strap_rate_100)
        && !machines_idle) [*5] |-> rate_100 == strap_rate_100) else $error("rate not pin");
    hw_dup_a: assert property ((!hardware_strap_select_pin && $stable(strap_full_duplex)
        && !machines_idle) [*5] |-> full_duplex == strap_full_duplex) else $error("duplex");
    quiet_busy_a: assert property (machines_idle |-> !mdio_oe)
        else $error("drive during soft reset");
    ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_o)
        else $error("turnaround not zero");
    restart_gate_a: assert property ($rose(an_restart) |-> an_enable)
        else $error("restart without negotiation");
    restart_clr_a: assert property (an_restart && an_started |-> ##[1:3] !an_restart)
        else $error("restart not cleared");
    reset_len_a: assert property ($fell(machines_idle)
        |-> idle_cnt_ff inside {[SW_RESET_CYC - 1:SW_RESET_CYC + 1]}) else $error("busy len");
endmodule
bind phy_mgmt_control_register phy_mgmt_control_register_asserts #(
    .SW_RESET_CYC(SW_RESET_CYC)) phy_mgmt_control_register_asserts_inst (.*);
`default_nettype wire

//--- mgmt_station.sv
// station management model driving management frames
`timescale 1ns/1ps
`default_nettype none
module mgmt_station (
    // clock and wire level
    input  wire logic clk,
    input  wire logic mdio_in,
    // station drive
    output logic      mdc,
    output logic      sta_o,
    output logic      sta_oe
);
    // ----------------------------------------------------------------
    // frame tasks
    // ----------------------------------------------------------------
    initial begin
        mdc = 1'b0;
        sta_o = 1'b1;
        sta_oe = 1'b0;
    end
    // slow clock: sixteen cycles a bit, sampled just before the rise
    task automatic bit_io(input logic b, input logic dr, output logic s);
        mdc = 1'b0;
        sta_o = b;
        sta_oe = dr;
        repeat (8) @(negedge clk);
        s = mdio_in;
        mdc = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [17:0] hdr;
        logic [15:0] dat;
        logic        wr;
        logic        s;
        hdr = {4'hf, 2'h1, op, pa, ra};
        wr = (op == phy_mgmt_pkg::OP_WRITE);
        dat = wd & 16'hff80;
        for (int i = 17; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
        bit_io(1'b1, wr, s);
        bit_io(1'b0, wr, s);
        for (int i = 15; i >= 0; i--) begin
            bit_io(dat[i], wr, s);
            rd[i] = s;
        end
        // release, then let an edge pass before any new frame
        sta_oe = 1'b0;
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- phy_mgmt_control_register_tb.sv
// self-checking bench for the management register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end end
module phy_mgmt_control_register_tb;
    // ----------------------------------------------------------------
    // signals, instances and scenarios
    // ----------------------------------------------------------------
    logic clk = 1'b0, sys_rst = 1'b1, mdc, sta_o, sta_oe, mdio_o, mdio_oe;
    logic hardware_strap_select_pin = 1'b1, strap_rate_100 = 1'b0;
    logic strap_an_en = 1'b0, strap_full_duplex = 1'b0, fault_event = 1'b0;
    logic link_ok = 1'b0, an_started = 1'b0, tx_en = 1'b0, line_rx_dv = 1'b0;
    logic line_col = 1'b0, rx_dv, col, tp_tx_en, tp_rx_en, col_det_en;
    logic rate_100, an_enable, an_restart, full_duplex, low_power, isolate;
    logic loopback, machines_idle;
    logic [4:0] phy_addr_strap = 5'h00;
    logic [2:0] train_state = 3'h0;
    logic [3:0] txd = 4'h0, line_rxd = 4'h0, rxd;
    logic [15:0] d;
    int failures = 0, num_checks = 0, cyc = 0;
    // released line is pulled up, so a silent device reads all ones
    wire mdio_w = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);
    phy_mgmt_control_register #(.SW_RESET_CYC(1500)) phy_mgmt_control_register_inst (
        .*, .mdio_i(mdio_w));
    mgmt_station mgmt_station_inst (.*, .mdio_in(mdio_w));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic rd(input logic [4:0] ra, output logic [15:0] v);
        mgmt_station_inst.xfer(phy_mgmt_pkg::OP_READ, phy_addr_strap, ra, 16'h0000, v);
    endtask
    task automatic wr(input logic [15:0] v);
        logic [15:0] x;
        mgmt_station_inst.xfer(phy_mgmt_pkg::OP_WRITE, phy_addr_strap, 5'h00, v, x);
    endtask
    task automatic do_reset(input logic [4:0] a);
        phy_addr_strap = a;
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic t_defaults;
        do_reset(5'h00);
        rd(5'h00, d);
        `CHK("isolate default", 16'h3400, d)
        `CHK("isolate pin", 1'b1, isolate)
        do_reset(5'h03);
        rd(5'h00, d);
        `CHK("ctrl default", 16'h3000, d)
        mgmt_station_inst.xfer(phy_mgmt_pkg::OP_READ, 5'h04, 5'h00, 16'h0000, d);
        `CHK("other address", 16'hffff, d)
        rd(5'h05, d);
        `CHK("unmapped", 16'h0000, d)
    endtask
    task automatic t_latch;
        link_ok = 1'b1;
        rd(5'h01, d);
        `CHK("event reset", 16'h0000, d)
        fault_event = 1'b1;
        link_ok = 1'b0;
        train_state = 3'h5;
        @(negedge clk);
        fault_event = 1'b0;
        link_ok = 1'b1;
        train_state = 3'h2;
        rd(5'h01, d);
        `CHK("event history", 16'h0015, d)
        rd(5'h01, d);
        `CHK("event current", 16'h000a, d)
        wr(16'h0800);
        `CHK("low power", 2'b10, {low_power, tp_tx_en})
        rd(5'h01, d);
        `CHK("latch reinit", 16'h0008, d)
    endtask
    task automatic t_loop;
        wr(16'h4180);
        rd(5'h00, d);
        `CHK("loop ctrl", 16'h4180, d)
        `CHK("line off", 4'b1001, {loopback, tp_tx_en, tp_rx_en, col_det_en})
        `CHK("sw settings", 3'b001, {rate_100, an_enable, full_duplex})
        tx_en = 1'b1;
        txd = 4'ha;
        repeat (4) @(negedge clk);
        `CHK("loop data", 6'h3a, {rx_dv, col, rxd})
        tx_en = 1'b0;
        wr(16'h4000);
        `CHK("detector off", 1'b0, col_det_en)
    endtask
    task automatic t_restart;
        wr(16'h0200);
        rd(5'h00, d);
        `CHK("restart refused", 16'h0000, d)
        wr(16'h1000);
        wr(16'h1200);
        `CHK("restart set", 1'b1, an_restart)
        an_started = 1'b1;
        @(negedge clk);
        an_started = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("restart clear", 1'b0, an_restart)
        rd(5'h00, d);
        `CHK("after restart", 16'h1000, d)
    endtask
    task automatic t_hw;
        hardware_strap_select_pin = 1'b0;
        strap_rate_100 = 1'b1;
        strap_full_duplex = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("hw mode", 3'b101, {rate_100, an_enable, full_duplex})
        hardware_strap_select_pin = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("sw mode", 3'b010, {rate_100, an_enable, full_duplex})
    endtask
    task automatic t_soft;
        wr(16'h8000);
        repeat (3) @(negedge clk);
        `CHK("busy", 1'b1, machines_idle)
        rd(5'h00, d);
        `CHK("access ignored", 16'hffff, d)
        for (int i = 0; i < 2000 && machines_idle === 1'b1; i++) @(negedge clk);
        `CHK("reset done", 1'b0, machines_idle)
        rd(5'h00, d);
        `CHK("defaults back", 16'h3000, d)
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        t_defaults();
        t_latch();
        t_loop();
        t_restart();
        t_hw();
        t_soft();
        give_verdict();
    end
endmodule
`default_nettype wire
